// ---- two_wire_pkg.sv ----
/*
 Shared constants for the two-wire slave port and its bus master end.
 Assumes one system clock of 200 MHz on both ends.
*/
package two_wire_pkg;
  // ==========================================================
  // Control byte
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;  // Value is arbitrary
  localparam int TYPE_POS = 4;
  localparam int SEL_POS = 1;
  localparam int DIR_POS = 0;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 200000000;
  localparam int SCL_STD_HZ = 100000;
  localparam int SCL_FAST_HZ = 400000;
  // Quarter period of the fast serial clock, rounded down
  localparam int QTR_FAST_CYC = CLK_HZ / (SCL_FAST_HZ * 4);
  localparam int QTR_STD_CYC = CLK_HZ / (SCL_STD_HZ * 4);
  localparam int WRITE_BUSY_NS = 10000;
  localparam int WRITE_BUSY_CYC = WRITE_BUSY_NS / (1000000000 / CLK_HZ);
  localparam int BYTE_BITS = 8;
endpackage : two_wire_pkg

// ---- two_wire_if.sv ----
/*
 Two-wire bus between master and slave port, open drain.
 Assumes pull-ups: a line is low while any party enables its driver.
*/
`timescale 1ns/1ps
interface two_wire_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;
  // ==========================================================
  // Wired-and resolution
  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
  modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m,
                  input scl, input sda);
  modport slave (output sda_o_s, output sda_oe_s, input scl, input sda);
endinterface : two_wire_if

// ---- two_wire_slave_port.sv ----
/*
 Slave end of the two-wire port: framing, control byte match, ack,
 receive of register address and one data byte, transmit of read data bytes.
 Assumes the master paces the bus; scl and sda are asynchronous pins.
*/
`timescale 1ns/1ps
module two_wire_slave_port #(
  parameter int BUSY_CYC = two_wire_pkg::WRITE_BUSY_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus
  two_wire_if.slave bus,
  // Address straps
  input wire logic addr_select_pin_low,
  input wire logic addr_select_pin_mid,
  input wire logic addr_select_pin_high,
  // Register side
  input wire logic [7:0] rd_data,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic busy
);
  typedef enum logic [2:0] {IDLE, RX, ACK, TX, TX_ACK} state_e;
  // ==========================================================
  // Synchronisers
  logic [1:0] scl_sync_q, sda_sync_q, scl_sync_d, sda_sync_d;
  logic [2:0] pin_sync_q, pin_sync_d, pin_q, pin_d;
  logic scl_q, sda_q, scl_d, sda_d;
  always_comb begin
    scl_sync_d = {scl_sync_q[0], bus.scl};
    sda_sync_d = {sda_sync_q[0], bus.sda};
    scl_d = scl_sync_q[1];
    sda_d = sda_sync_q[1];
    pin_sync_d = {addr_select_pin_high, addr_select_pin_mid, addr_select_pin_low};
    pin_d = pin_sync_q;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pin_sync_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      pin_sync_q <= pin_sync_d;
      pin_q <= pin_d;
    end
  end
  // Edges on the second stage; plenty of margin at 400 kHz
  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_c = scl_s && scl_q && !sda_s && sda_q;
  wire stop_c = scl_s && scl_q && sda_s && !sda_q;
  // ==========================================================
  // Protocol engine
  state_e state_q, state_d;
  logic [7:0] shift_q, shift_d, addr_q, addr_d, wdat_q, wdat_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] byte_q, byte_d;
  logic rd_q, rd_d, sda_oe_q, sda_oe_d, wr_q, wr_d, pend_q, pend_d;
  logic [31:0] busy_cnt_q, busy_cnt_d;
  logic ack_ok;
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    cnt_d = cnt_q;
    byte_d = byte_q;
    rd_d = rd_q;
    sda_oe_d = sda_oe_q;
    wr_d = 1'b0;
    pend_d = pend_q;
    busy_cnt_d = busy_cnt_q;
    ack_ok = 1'b0;
    if (busy_cnt_q != 32'h0) begin
      busy_cnt_d = busy_cnt_q - 32'h1;
    end
    if (start_c) begin
      state_d = (busy_cnt_q != 32'h0) ? IDLE : RX;
      cnt_d = 4'h0;
      byte_d = 2'h0;
      sda_oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (stop_c) begin
      state_d = IDLE;
      sda_oe_d = 1'b0;
      if (pend_q) begin
        wr_d = 1'b1;
        busy_cnt_d = 32'(BUSY_CYC);
      end
      pend_d = 1'b0;
    end else begin
      case (state_q)
        IDLE: sda_oe_d = 1'b0;
        RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (byte_q == 2'h0) begin
              ack_ok = shift_q[two_wire_pkg::TYPE_POS +: 4] == two_wire_pkg::DEV_TYPE_ID
                  && shift_q[two_wire_pkg::SEL_POS +: 3] == pin_q;
            end else begin
              ack_ok = byte_q != 2'h3;
            end
            if (ack_ok) begin
              state_d = ACK;
              sda_oe_d = 1'b1;
              if (byte_q == 2'h0) begin
                rd_d = shift_q[two_wire_pkg::DIR_POS] == two_wire_pkg::DIR_READ;
              end else if (byte_q == 2'h1) begin
                addr_d = shift_q;
              end else begin
                wdat_d = shift_q;
                pend_d = 1'b1;
              end
            end else begin
              state_d = IDLE;
            end
          end
        end
        ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            byte_d = (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
            if (byte_q == 2'h0 && rd_q) begin
              state_d = TX;
              shift_d = rd_data;
              sda_oe_d = !rd_data[7];
            end else begin
              state_d = RX;
              sda_oe_d = 1'b0;
            end
          end
        end
        TX: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              state_d = TX_ACK;
              sda_oe_d = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sda_oe_d = !shift_q[6];
            end
          end
        end
        TX_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_d = IDLE;
            end else begin
              shift_d = rd_data;
            end
          end else if (scl_fall) begin
            state_d = TX;
            cnt_d = 4'h0;
            sda_oe_d = !shift_q[7];
          end
        end
        default: state_d = IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= IDLE;
      shift_q <= 8'h00;
      addr_q <= 8'h00;
      wdat_q <= 8'h00;
      cnt_q <= 4'h0;
      byte_q <= 2'h0;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_q <= 1'b0;
      pend_q <= 1'b0;
      busy_cnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      cnt_q <= cnt_d;
      byte_q <= byte_d;
      rd_q <= rd_d;
      sda_oe_q <= sda_oe_d;
      wr_q <= wr_d;
      pend_q <= pend_d;
      busy_cnt_q <= busy_cnt_d;
    end
  end
  // Open drain: drive only a low
  assign bus.sda_o_s = 1'b0;
  assign bus.sda_oe_s = sda_oe_q;
  assign reg_addr = addr_q;
  assign wr_data = wdat_q;
  assign wr_strobe = wr_q;
  // Busy raised with the strobe
  logic busy_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_cnt_d != 32'h0;
    end
  end
  assign busy = busy_q;
endmodule : two_wire_slave_port

// ---- two_wire_master.sv ----
/*
 Master end of the two-wire bus: one write (control, address, data)
 or one read (address write, restart, control, one byte, nack, stop).
 Assumes a request pulse with stable fields until done.
*/
`timescale 1ns/1ps
module two_wire_master #(
  parameter int QTR_CYC = two_wire_pkg::QTR_FAST_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus
  two_wire_if.master bus,
  // Request
  input wire logic req,
  input wire logic req_read,
  input wire logic [2:0] req_sel,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  // Answer
  output logic done,
  output logic nacked,
  output logic [7:0] rd_byte
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} state_e;
  state_e st_q, st_d;
  logic [15:0] tick_q, tick_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] seq_q, seq_d;
  logic [7:0] sh_q, sh_d, rd_q, rd_d;
  logic scl_q, scl_d, sda_q, sda_d, nak_q, nak_d, done_q, done_d;
  logic [1:0] sda_in_q, sda_in_d;
  wire step = tick_q == 16'(QTR_CYC - 1);
  wire rx = (seq_q == 3'h4);
  function automatic logic [7:0] ctrl_byte(input logic [2:0] sel, input logic dir);
    ctrl_byte = {two_wire_pkg::DEV_TYPE_ID, sel, dir};
  endfunction : ctrl_byte
  always_comb begin
    st_d = st_q;
    tick_d = step ? 16'h0 : tick_q + 16'h1;
    ph_d = ph_q;
    bit_d = bit_q;
    seq_d = seq_q;
    sh_d = sh_q;
    rd_d = rd_q;
    scl_d = scl_q;
    sda_d = sda_q;
    nak_d = nak_q;
    done_d = 1'b0;
    sda_in_d = {sda_in_q[0], bus.sda};
    case (st_q)
      M_IDLE: begin
        if (req) begin
          st_d = M_START;
          ph_d = 2'h0;
          seq_d = 3'h0;
          nak_d = 1'b0;
          sh_d = ctrl_byte(req_sel, two_wire_pkg::DIR_WRITE);
        end
      end
      M_START: if (step) begin  // Start or restart, SDA falls with SCL high
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sda_d = 1'b1;
          2'h1: scl_d = 1'b1;
          2'h2: sda_d = 1'b0;
          default: begin
            scl_d = 1'b0;
            st_d = M_BIT;
            bit_d = 4'h0;
          end
        endcase
      end
      M_BIT: if (step) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: begin  // SCL low: drive data or release
            if (bit_q == 4'h8) begin
              // Release: slave acks, and the single read byte gets a nack
              sda_d = 1'b1;
            end else begin
              sda_d = rx ? 1'b1 : sh_q[7];
            end
          end
          2'h1: scl_d = 1'b1;
          2'h2: begin  // Sample mid high
            if (bit_q == 4'h8) begin
              if (!rx && sda_in_q[1]) begin
                nak_d = 1'b1;
              end
            end else begin
              rd_d = {rd_q[6:0], sda_in_q[1]};
              sh_d = {sh_q[6:0], 1'b0};
            end
          end
          default: begin
            scl_d = 1'b0;
            ph_d = 2'h0;
            if (bit_q == 4'h8) begin
              bit_d = 4'h0;
              seq_d = seq_q + 3'h1;
              if (nak_q || rx) begin
                st_d = M_STOP;
              end else if (seq_q == 3'h0) begin
                sh_d = req_addr;
              end else if (seq_q == 3'h1) begin
                if (req_read) begin
                  st_d = M_START;
                  sh_d = ctrl_byte(req_sel, two_wire_pkg::DIR_READ);
                end else begin
                  sh_d = req_data;
                end
              end else if (seq_q == 3'h2) begin
                st_d = M_STOP;
              end
              if (seq_q == 3'h1 && req_read) begin
                seq_d = 3'h3;
              end
            end else begin
              bit_d = bit_q + 4'h1;
            end
          end
        endcase
      end
      M_STOP: if (step) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sda_d = 1'b0;
          2'h1: scl_d = 1'b1;
          2'h2: sda_d = 1'b1;
          default: st_d = M_DONE;
        endcase
      end
      M_DONE: begin
        done_d = 1'b1;
        st_d = M_IDLE;
      end
      default: st_d = M_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= M_IDLE;
      tick_q <= 16'h0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      seq_q <= 3'h0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nak_q <= 1'b0;
      done_q <= 1'b0;
      sda_in_q <= 2'h3;
    end else begin
      st_q <= st_d;
      tick_q <= tick_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      seq_q <= seq_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      nak_q <= nak_d;
      done_q <= done_d;
      sda_in_q <= sda_in_d;
    end
  end
  // Open drain: enable only while pulling low
  assign bus.scl_o_m = 1'b0;
  assign bus.scl_oe_m = !scl_q;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_m = !sda_q;
  assign done = done_q;
  assign nacked = nak_q;
  assign rd_byte = rd_q;
endmodule : two_wire_master

// ---- two_wire_monitor.sv ----
/*
 Checker of the resolved two-wire lines and the slave driver.
 Assumes one system clock samples the lines of the interface.
*/
`timescale 1ns/1ps
module two_wire_monitor #(
  parameter int QTR_CYC = two_wire_pkg::QTR_FAST_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_s
);
  // ==========================================================
  // Line history, phase lengths, bit count
  logic scl_p_q, scl_p_d, sda_p_q, sda_p_d, first_q, first_d;
  logic [15:0] hi_q, hi_d, lo_q, lo_d;
  logic [3:0] bit_q, bit_d;
  always_comb begin
    scl_p_d = scl;
    sda_p_d = sda;
    // Idle gaps stay well under the counter range
    hi_d = scl ? hi_q + 16'h0001 : 16'h0000;
    lo_d = scl ? 16'h0000 : lo_q + 16'h0001;
    bit_d = bit_q;
    first_d = first_q;
    if (scl && scl_p_q && sda_p_q && !sda) begin
      bit_d = 4'h0;
      first_d = 1'b1;
    end else if (scl && !scl_p_q) begin
      bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      first_d = first_q && (bit_q != 4'h8);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      bit_q <= 4'h0;
      first_q <= 1'b0;
    end else begin
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      bit_q <= bit_d;
      first_q <= first_d;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_oe_low; $changed(sda_oe_s) |-> !scl; endproperty
  property p_ack_low; $rose(scl) && sda_oe_s |-> !sda [*8]; endproperty
  property p_hi_len; $fell(scl) |-> hi_q >= QTR_CYC; endproperty
  property p_lo_len; $rose(scl) |-> lo_q >= QTR_CYC; endproperty
  property p_ctrl_listen;
    scl && !scl_p_q && first_q && bit_q < 4'h8 |-> !sda_oe_s;
  endproperty
  property p_start_master; scl && scl_p_q && sda_p_q && !sda |-> !sda_oe_s; endproperty
  property p_stop_idle; scl && scl_p_q && !sda_p_q && sda |=> scl && sda; endproperty
  property p_reset_idle; $rose(rst_n) |-> scl && sda; endproperty
  a_oe_low: assert property (p_oe_low) else $error("slave sda moved in scl high");
  a_ack_low: assert property (p_ack_low) else $error("slave low not held");
  a_hi_len: assert property (p_hi_len) else $error("scl high too short");
  a_lo_len: assert property (p_lo_len) else $error("scl low too short");
  a_ctrl_listen: assert property (p_ctrl_listen) else $error("slave drove control");
  a_start_master: assert property (p_start_master) else $error("slave made start");
  a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle at reset");
  c_start: cover property (scl && scl_p_q && sda_p_q && !sda);
  c_ack: cover property ($rose(scl) && sda_oe_s);
  c_send: cover property (scl && !scl_p_q && !first_q && bit_q < 4'h8 && sda_oe_s);
endmodule : two_wire_monitor

// ---- testbench.sv ----
/*
 Self-checking bench: master end and slave port on one bus.
 Assumes the fast serial clock and a shortened write busy time.
*/
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Stimulus and model state
  localparam int BUSY = 1500;
  localparam int LIMIT = 40000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] straps = 3'h0;
  logic [7:0] rd_data = 8'h00;
  logic req = 1'b0;
  logic req_read = 1'b0;
  logic [2:0] req_sel = 3'h0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic [7:0] reg_addr, wr_data, rd_byte;
  logic wr_strobe, busy, done, nacked;
  int mismatches = 0;
  int compares = 0;
  int wr_q[$];
  always #2.5 clk_sys = ~clk_sys;
  two_wire_if bus ();
  two_wire_slave_port #(.BUSY_CYC(BUSY)) u_two_wire_slave_port (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.slave),
    .addr_select_pin_low(straps[0]), .addr_select_pin_mid(straps[1]),
    .addr_select_pin_high(straps[2]), .rd_data(rd_data), .reg_addr(reg_addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .busy(busy));
  two_wire_master #(.QTR_CYC(two_wire_pkg::QTR_FAST_CYC)) u_two_wire_master (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.master), .req(req),
    .req_read(req_read), .req_sel(req_sel), .req_addr(req_addr),
    .req_data(req_data), .done(done), .nacked(nacked), .rd_byte(rd_byte));
  two_wire_monitor #(.QTR_CYC(two_wire_pkg::QTR_FAST_CYC)) u_two_wire_monitor (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
    .sda_oe_s(bus.sda_oe_s));
  // ==========================================================
  // Compare and report
  task automatic fail(input string msg);
    $display("wrong value at %0t: %s", $time, msg);
    mismatches++;
  endtask : fail
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) fail(msg);
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) fail(msg);
  endtask : cmp_bit
  task automatic summarize();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // Each strobe must match the oldest write the model expects
  // Sampled on the falling edge, where the strobe has settled
  always @(negedge clk_sys) begin
    if (wr_strobe === 1'b1) begin
      if (wr_q.size() == 0) begin
        fail("unexpected write strobe");
      end else begin
        cmp_byte(reg_addr, 8'(wr_q[0] >> 8), "strobe address");
        cmp_byte(wr_data, 8'(wr_q[0]), "strobe data");
        void'(wr_q.pop_front());
      end
    end
  end
  // ==========================================================
  // Master requests
  task automatic xfer(input logic rd, input logic [2:0] sel, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    @(negedge clk_sys);
    req = 1'b1;
    req_read = rd;
    req_sel = sel;
    req_addr = a;
    req_data = d;
    @(negedge clk_sys);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < LIMIT) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == LIMIT) begin
      fail("no done");
      summarize();
    end
  endtask : xfer
  task automatic wait_free();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < LIMIT) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == LIMIT) begin
      fail("busy stuck");
      summarize();
    end
  endtask : wait_free
  // ==========================================================
  // Scenarios
  initial begin
    int st;
    int a;
    int d;
    void'($urandom(32'hefaf11d3));
    st = $urandom_range(7);
    straps = 3'(st);
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    cmp_bit(bus.scl, 1'b1, "scl idle");
    cmp_bit(bus.sda, 1'b1, "sda idle");
    a = $urandom_range(255);
    d = $urandom_range(255);
    rd_data = 8'(d);
    xfer(1'b1, 3'(st), 8'(a), 8'h00);
    cmp_byte(rd_byte, 8'(d), "read byte");
    cmp_bit(nacked, 1'b0, "read acks");
    cmp_byte(reg_addr, 8'(a), "read address");
    $display("test read done");
    // Slave must be idle again after the read nack
    for (int s = 0; s < 8; s++) begin
      a = $urandom_range(255);
      d = $urandom_range(255);
      if (s == st) wr_q.push_back(a * 256 + d);
      xfer(1'b0, 3'(s), 8'(a), 8'(d));
      cmp_bit(nacked, 1'(s != st), "select match");
      if (s == st) begin
        cmp_bit(busy, 1'b1, "busy after write");
        xfer(1'b0, 3'(s), 8'(a ^ 1), 8'(d ^ 1));
        cmp_bit(nacked, 1'b1, "nack while busy");
        wait_free();
        cmp_bit(1'(wr_q.size() == 0), 1'b1, "write strobes");
        cmp_byte(wr_data, 8'(d), "write data");
      end
    end
    $display("test select done");
    summarize();
  end
endmodule : testbench
